/* lmc_pkg.sv */
// lmc_pkg: constants of the logger mission configuration block.
// assumes a 200 MHz core clock and byte-wide register access.
package lmc_pkg;
  // ==========================================================
  // register addresses
  localparam logic [9:0] LMC_CFG_FIRST = 10'h200;
  localparam logic [9:0] LMC_CFG_LAST = 10'h213;
  localparam logic [9:0] LMC_ADDR_LOW_TH = 10'h20b;
  localparam logic [9:0] LMC_ADDR_HIGH_TH = 10'h20c;
  localparam logic [9:0] LMC_ADDR_INTERVAL = 10'h20d;
  localparam logic [9:0] LMC_ADDR_CONTROL = 10'h20e;
  localparam logic [9:0] LMC_ADDR_FORCED = 10'h211;
  localparam logic [9:0] LMC_ADDR_DELAY_LO = 10'h212;
  localparam logic [9:0] LMC_ADDR_DELAY_HI = 10'h213;
  localparam logic [9:0] LMC_ADDR_STATUS = 10'h214;
  // ==========================================================
  // control and status bit positions
  localparam int LMC_CTL_OSC_STOP = 7;
  localparam int LMC_CTL_CLEAR_ARM = 6;
  localparam int LMC_CTL_NOFUNC = 5;
  localparam int LMC_CTL_MISSION_EN_N = 4;
  localparam int LMC_CTL_LOG_WRAP = 3;
  localparam int LMC_CTL_LOW_SEARCH = 2;
  localparam int LMC_CTL_HIGH_SEARCH = 1;
  localparam int LMC_CTL_ALARM_SEARCH = 0;
  localparam int LMC_ST_MEM_CLEARED = 6;
  localparam int LMC_ST_MISSION = 5;
  localparam int LMC_ST_LOW = 2;
  localparam int LMC_ST_HIGH = 1;
  localparam int LMC_ST_TIMER = 0;
  // ==========================================================
  // reset values and codes
  localparam logic [7:0] LMC_CTL_RESET = 8'h00;
  localparam logic [7:0] LMC_CODE_UNDER = 8'h00;
  localparam logic [7:0] LMC_CODE_OVER = 8'hff;
  localparam logic [7:0] LMC_CODE_MIN_VALID = 8'h01;
  localparam logic [7:0] LMC_CODE_MAX_VALID = 8'hfe;
  // code = eighths of a degree plus this offset (variant dependent)
  localparam int LMC_CODE_OFFSET_H = -116;
  localparam int LMC_CODE_OFFSET_Z = 44;
  // ==========================================================
  // timing: one minute tick from the core clock
  localparam longint unsigned LMC_CLK_HZ = 64'd200_000_000;
  localparam longint unsigned LMC_MINUTE_S = 64'd60;
  localparam longint unsigned LMC_MINUTE_CYCLES = LMC_MINUTE_S * LMC_CLK_HZ;
  typedef enum logic [1:0] {LMC_IDLE, LMC_DELAY, LMC_SAMPLE} lmc_phase_t;
endpackage

/* lmc_core_if.sv */
// lmc_core_if: signals shared between the top and its helpers.
// assumes all parties run on the one core clock.
`timescale 1ns/1ps
interface lmc_core_if;
  logic osc_run;
  logic minute_tick;
  logic signed [11:0] raw_eighths;
  logic [7:0] code;
  logic [7:0] low_th;
  logic [7:0] high_th;
  logic low_hit;
  logic high_hit;
  modport top (output osc_run, input minute_tick, output raw_eighths,
    input code, output low_th, output high_th, input low_hit, input high_hit);
  modport ticker (input osc_run, output minute_tick);
  modport coder (input raw_eighths, output code, input low_th, input high_th,
    output low_hit, output high_hit);
endinterface

/* lmc_minute_tick.sv */
// lmc_minute_tick: one-cycle minute enable from the core clock.
// assumes osc_run low freezes time, as a stopped oscillator would.
`timescale 1ns/1ps
module lmc_minute_tick import lmc_pkg::*; #(
  parameter longint unsigned TICK_CYCLES = LMC_MINUTE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // core side
  lmc_core_if.ticker core
);
  logic [39:0] cnt_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
      core.minute_tick <= 1'b0;
    end else if (!core.osc_run) begin
      core.minute_tick <= 1'b0;
    end else if (cnt_q == 40'(TICK_CYCLES - 1)) begin
      cnt_q <= '0;
      core.minute_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 40'h1;
      core.minute_tick <= 1'b0;
    end
  end
endmodule

/* lmc_temp_coder.sv */
// lmc_temp_coder: raw eighths of a degree to the one-byte code.
// assumes the raw reading is already a signed count of 1/8 degree.
`timescale 1ns/1ps
module lmc_temp_coder import lmc_pkg::*; #(
  parameter int CODE_OFFSET = LMC_CODE_OFFSET_H
) (
  lmc_core_if.coder core
);
  logic signed [13:0] sum;

  always_comb begin
    sum = 14'(core.raw_eighths) + 14'(CODE_OFFSET);
    // 00 and ff are reserved for out-of-range
    if (sum < $signed(14'(LMC_CODE_MIN_VALID))) begin
      core.code = LMC_CODE_UNDER;
    end else if (sum > $signed(14'(LMC_CODE_MAX_VALID))) begin
      core.code = LMC_CODE_OVER;
    end else begin
      core.code = sum[7:0];
    end
    core.low_hit = core.code <= core.low_th;
    core.high_hit = core.code >= core.high_th;
  end
endmodule

/* lmc_mission_cfg.sv */
// lmc_mission_cfg: mission configuration registers and sequencing.
// assumes writes arrive already committed from the scratchpad copy,
// one byte per cycle, and that conversions report back with conv_valid_i.
// Contract
// - temperature is one unsigned byte code; 01h..FEh are valid readings.
// - below range records 00h, above range records FFh.
// - one code step is 1/8 degree, linear with variant offset.
// - log and forced-conversion readout use the same encoding.
// - low and high thresholds are byte codes at their own addresses.
// - sample interval is minutes between conversions, 1 to 255.
// - nonzero interval write starts mission if memory cleared and enable low.
// - first control write in mission ends it unchanged; later writes update.
// - control bit 5 always reads zero and cannot be set.
// - control bit 7 high stops oscillator, entering low-power retention.
// - bit 6 arms clear-memory; clear works only as the next command.
// - clear arm returns to zero at the next memory function command.
// - control bit 4 is active-low mission enable.
// - bit 3 high lets the log wrap and overwrite oldest samples.
// - bit 3 low stops logging when full; mission and histogram continue.
// - bit 2 answers conditional search after a low-threshold hit.
// - bit 1 answers conditional search after a high-threshold hit.
// - bit 0 answers conditional search after an RTC alarm.
// - start delay is a 16-bit minute count, low then high byte.
// - first conversion after delay plus one interval, then interval apart.
// - memory-cleared flag drops when a mission is started.
// - first write into the configuration range in mission ends it.
// - low flag on code at or below low, high flag at or above high.
`timescale 1ns/1ps
module lmc_mission_cfg import lmc_pkg::*; #(
  parameter longint unsigned TICK_CYCLES = LMC_MINUTE_CYCLES,
  parameter int CODE_OFFSET = LMC_CODE_OFFSET_H
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register write and read
  input wire logic wr_i,
  input wire logic [9:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [9:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // memory function commands
  input wire logic mem_cmd_i,
  input wire logic mem_cmd_clear_i,
  // temperature core and rtc
  input wire logic conv_valid_i,
  input wire logic signed [11:0] conv_raw_i,
  input wire logic rtc_alarm_i,
  input wire logic log_full_i,
  output logic conv_req_o,
  output logic log_store_o,
  output logic hist_update_o,
  output logic [7:0] conv_code_o,
  // mission state and search
  output logic mission_active_o,
  output logic low_power_o,
  output logic search_match_o,
  output logic clear_mem_o
);
  lmc_core_if core ();

  logic [7:0] low_th_q;
  logic [7:0] high_th_q;
  logic [7:0] interval_q;
  logic [7:0] control_q;
  logic [15:0] delay_q;
  logic [7:0] forced_q;
  logic mission_active;
  logic memory_cleared_flag;
  logic low_temp_flag;
  logic high_temp_flag;
  logic timer_alarm_flag;
  lmc_phase_t phase_q;
  logic [15:0] delay_cnt_q;
  logic [7:0] interval_cnt_q;
  logic mission_start;
  logic mission_kill;
  logic cfg_write;
  logic status_write;
  logic cfg_wr_ok;
  logic do_clear;

  // ==========================================================
  // helpers
  lmc_minute_tick #(.TICK_CYCLES(TICK_CYCLES)) i_lmc_minute_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .core(core)
  );

  lmc_temp_coder #(.CODE_OFFSET(CODE_OFFSET)) i_lmc_temp_coder (
    .core(core)
  );

  assign core.osc_run = ~control_q[LMC_CTL_OSC_STOP];
  assign core.raw_eighths = conv_raw_i;
  assign core.low_th = low_th_q;
  assign core.high_th = high_th_q;

  // ==========================================================
  // write decode
  function automatic logic in_cfg(input logic [9:0] a);
    return a >= LMC_CFG_FIRST && a <= LMC_CFG_LAST;
  endfunction

  assign cfg_write = wr_i && in_cfg(wr_addr_i);
  assign status_write = wr_i && wr_addr_i == LMC_ADDR_STATUS;
  // in a mission the write only ends it and stores nothing
  assign cfg_wr_ok = cfg_write && !mission_active;
  assign mission_kill = mission_active && (cfg_write ||
    (status_write && !wr_data_i[LMC_ST_MISSION]));
  assign mission_start = cfg_wr_ok && wr_addr_i == LMC_ADDR_INTERVAL &&
    wr_data_i != 8'h00 && memory_cleared_flag &&
    !control_q[LMC_CTL_MISSION_EN_N];
  assign do_clear = mem_cmd_i && mem_cmd_clear_i &&
    control_q[LMC_CTL_CLEAR_ARM] && !mission_active;

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_th_q <= 8'h00;
      high_th_q <= 8'h00;
    end else if (cfg_wr_ok && wr_addr_i == LMC_ADDR_LOW_TH) begin
      low_th_q <= wr_data_i;
    end else if (cfg_wr_ok && wr_addr_i == LMC_ADDR_HIGH_TH) begin
      high_th_q <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      interval_q <= 8'h00;
      delay_q <= 16'h0000;
    end else if (do_clear) begin
      interval_q <= 8'h00;
      delay_q <= 16'h0000;
    end else if (cfg_wr_ok && wr_addr_i == LMC_ADDR_INTERVAL) begin
      interval_q <= wr_data_i;
    end else if (cfg_wr_ok && wr_addr_i == LMC_ADDR_DELAY_LO) begin
      delay_q[7:0] <= wr_data_i;
    end else if (cfg_wr_ok && wr_addr_i == LMC_ADDR_DELAY_HI) begin
      delay_q[15:8] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      control_q <= LMC_CTL_RESET;
    end else begin
      if (cfg_wr_ok && wr_addr_i == LMC_ADDR_CONTROL) begin
        control_q <= wr_data_i;
        control_q[LMC_CTL_NOFUNC] <= 1'b0;
      end
      // any memory command consumes the arm, clear or not
      if (mem_cmd_i) begin
        control_q[LMC_CTL_CLEAR_ARM] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status flags; hardware set wins over software clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mission_active <= 1'b0;
      memory_cleared_flag <= 1'b0;
    end else begin
      if (mission_start) begin
        mission_active <= 1'b1;
      end else if (mission_kill) begin
        mission_active <= 1'b0;
      end
      if (do_clear) begin
        memory_cleared_flag <= 1'b1;
      end else if (mission_start) begin
        memory_cleared_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_temp_flag <= 1'b0;
      high_temp_flag <= 1'b0;
      timer_alarm_flag <= 1'b0;
    end else begin
      if (conv_valid_i && mission_active && core.low_hit) begin
        low_temp_flag <= 1'b1;
      end else if (status_write && !wr_data_i[LMC_ST_LOW]) begin
        low_temp_flag <= 1'b0;
      end
      if (conv_valid_i && mission_active && core.high_hit) begin
        high_temp_flag <= 1'b1;
      end else if (status_write && !wr_data_i[LMC_ST_HIGH]) begin
        high_temp_flag <= 1'b0;
      end
      if (rtc_alarm_i) begin
        timer_alarm_flag <= 1'b1;
      end else if (status_write && !wr_data_i[LMC_ST_TIMER]) begin
        timer_alarm_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // mission timing: delay, then one interval per sample
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q <= LMC_IDLE;
      delay_cnt_q <= 16'h0000;
      interval_cnt_q <= 8'h00;
      conv_req_o <= 1'b0;
    end else begin
      conv_req_o <= 1'b0;
      if (mission_start) begin
        delay_cnt_q <= delay_q;
        interval_cnt_q <= wr_data_i;
        phase_q <= (delay_q == 16'h0000) ? LMC_SAMPLE : LMC_DELAY;
      end else if (mission_kill) begin
        phase_q <= LMC_IDLE;
      end else if (core.minute_tick) begin
        case (phase_q)
          LMC_DELAY: begin
            delay_cnt_q <= delay_cnt_q - 16'h1;
            if (delay_cnt_q == 16'h1) begin
              phase_q <= LMC_SAMPLE;
            end
          end
          LMC_SAMPLE: begin
            if (interval_cnt_q == 8'h1) begin
              interval_cnt_q <= interval_q;
              conv_req_o <= 1'b1;
            end else begin
              interval_cnt_q <= interval_cnt_q - 8'h1;
            end
          end
          default: begin
            phase_q <= LMC_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // conversion results into log, histogram and readout
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      forced_q <= 8'h00;
      conv_code_o <= 8'h00;
      log_store_o <= 1'b0;
      hist_update_o <= 1'b0;
    end else begin
      log_store_o <= 1'b0;
      hist_update_o <= 1'b0;
      if (conv_valid_i) begin
        forced_q <= core.code;
        conv_code_o <= core.code;
        if (mission_active) begin
          hist_update_o <= 1'b1;
          log_store_o <= control_q[LMC_CTL_LOG_WRAP] || !log_full_i;
        end
      end
    end
  end

  // ==========================================================
  // outputs and read mux
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mission_active_o <= 1'b0;
      low_power_o <= 1'b0;
      search_match_o <= 1'b0;
      clear_mem_o <= 1'b0;
    end else begin
      mission_active_o <= mission_active;
      low_power_o <= control_q[LMC_CTL_OSC_STOP];
      search_match_o <= (control_q[LMC_CTL_LOW_SEARCH] && low_temp_flag) ||
        (control_q[LMC_CTL_HIGH_SEARCH] && high_temp_flag) ||
        (control_q[LMC_CTL_ALARM_SEARCH] && timer_alarm_flag);
      clear_mem_o <= do_clear;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      case (rd_addr_i)
        LMC_ADDR_LOW_TH: rd_data_o <= low_th_q;
        LMC_ADDR_HIGH_TH: rd_data_o <= high_th_q;
        LMC_ADDR_INTERVAL: rd_data_o <= interval_q;
        LMC_ADDR_CONTROL: rd_data_o <= control_q;
        LMC_ADDR_FORCED: rd_data_o <= forced_q;
        LMC_ADDR_DELAY_LO: rd_data_o <= delay_q[7:0];
        LMC_ADDR_DELAY_HI: rd_data_o <= delay_q[15:8];
        LMC_ADDR_STATUS: rd_data_o <= {1'b1, memory_cleared_flag, mission_active,
          2'b00, low_temp_flag, high_temp_flag, timer_alarm_flag};
        default: rd_data_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // checks
  // reference sum kept apart from the coder's arithmetic
  logic signed [31:0] ref_sum;
  assign ref_sum = 32'(conv_raw_i) + 32'(CODE_OFFSET);

  property p_code_range;
    @(posedge clk_i) disable iff (!nrst_i)
    conv_valid_i |=> conv_code_o == (($past(ref_sum) < $signed(32'(LMC_CODE_MIN_VALID))) ?
      LMC_CODE_UNDER : (($past(ref_sum) > $signed(32'(LMC_CODE_MAX_VALID))) ?
      LMC_CODE_OVER : 8'($past(ref_sum))));
  endproperty
  a_code_range: assert property (p_code_range) else $error("code out of encoding");

  property p_start;
    @(posedge clk_i) disable iff (!nrst_i)
    mission_start |=> mission_active && !memory_cleared_flag ##1 mission_active_o;
  endproperty
  a_start: assert property (p_start) else $error("mission did not start");

  property p_ctl_keep;
    @(posedge clk_i) disable iff (!nrst_i)
    (mission_active && wr_i && wr_addr_i == LMC_ADDR_CONTROL) |=>
      control_q == $past(control_q) && !mission_active;
  endproperty
  a_ctl_keep: assert property (p_ctl_keep) else $error("control changed at kill");

  property p_bit5;
    @(posedge clk_i) disable iff (!nrst_i)
    !control_q[LMC_CTL_NOFUNC];
  endproperty
  a_bit5: assert property (p_bit5) else $error("control bit 5 set");

  property p_osc;
    @(posedge clk_i) disable iff (!nrst_i)
    control_q[LMC_CTL_OSC_STOP] [*2] |-> !core.minute_tick ##1 low_power_o;
  endproperty
  a_osc: assert property (p_osc) else $error("tick while stopped");

  property p_arm;
    @(posedge clk_i) disable iff (!nrst_i)
    mem_cmd_i |=> !control_q[LMC_CTL_CLEAR_ARM];
  endproperty
  a_arm: assert property (p_arm) else $error("clear arm kept");

  property p_nowrap;
    @(posedge clk_i) disable iff (!nrst_i)
    (conv_valid_i && mission_active && log_full_i && !control_q[LMC_CTL_LOG_WRAP])
      |=> !log_store_o && hist_update_o;
  endproperty
  a_nowrap: assert property (p_nowrap) else $error("stored into full log");

  property p_low_flag;
    @(posedge clk_i) disable iff (!nrst_i)
    (conv_valid_i && mission_active && core.code <= low_th_q) |=> low_temp_flag;
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag missed");

  property p_kill;
    @(posedge clk_i) disable iff (!nrst_i)
    (mission_active && cfg_write) |=> !mission_active ##1 !mission_active_o;
  endproperty
  a_kill: assert property (p_kill) else $error("mission kept after write");
endmodule

/* lmc_conv_model.sv */
// lmc_conv_model: temperature core seen from the configuration block.
// assumes one core clock; a request or a forced start is answered after LAT cycles.
`timescale 1ns/1ps
module lmc_conv_model #(
  parameter int LAT = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // requests
  input wire logic conv_req_i,
  input wire logic force_i,
  input wire logic signed [11:0] raw_i,
  // result
  output logic conv_valid_o,
  output logic signed [11:0] conv_raw_o
);
  // ==========================================================
  // conversion timer
  int cnt_q;
  logic signed [11:0] last_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 0;
      conv_valid_o <= 1'b0;
      conv_raw_o <= 12'h000;
      last_q <= 12'h000;
    end else begin
      conv_valid_o <= 1'b0;
      // result lines are not held outside the valid cycle
      conv_raw_o <= ~last_q;
      if (cnt_q == 1) begin
        conv_valid_o <= 1'b1;
        conv_raw_o <= raw_i;
        last_q <= raw_i;
      end
      if (conv_req_i || force_i) begin
        cnt_q <= LAT;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule

/* lmc_mission_cfg_tb_top.sv */
// lmc_mission_cfg_tb_top: register-level tests of the mission configuration block.
// assumes a short minute tick and the conversion model as temperature core.
`timescale 1ns/1ps
module lmc_mission_cfg_tb_top import lmc_pkg::*; ;
  localparam int TICK_N = 10;
  localparam int LAT = 3;
  localparam int RAWS [7] = '{184, 117, 370, 115, 371, 500, -40};
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wr_i = 1'b0;
  logic [9:0] wr_addr_i = 10'h000;
  logic [7:0] wr_data_i = 8'h00;
  logic [9:0] rd_addr_i = 10'h000;
  logic mem_cmd_i = 1'b0;
  logic mem_cmd_clear_i = 1'b0;
  logic rtc_alarm_i = 1'b0;
  logic log_full_i = 1'b0;
  logic force_q = 1'b0;
  logic signed [11:0] raw_q = 12'h000;
  logic conv_valid;
  logic signed [11:0] conv_raw;
  logic [7:0] rd_data_o;
  logic [7:0] conv_code_o;
  logic conv_req_o, log_store_o, hist_update_o, mission_active_o;
  logic low_power_o, search_match_o, clear_mem_o;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0, n_req = 0, n_store = 0, n_hist = 0, n_clr = 0;
  int t_req = 0, t0 = 0, t1 = 0, n0 = 0;

  lmc_mission_cfg #(.TICK_CYCLES(64'(TICK_N)), .CODE_OFFSET(LMC_CODE_OFFSET_H)) i_lmc_mission_cfg (
    .clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .mem_cmd_i(mem_cmd_i), .mem_cmd_clear_i(mem_cmd_clear_i),
    .conv_valid_i(conv_valid), .conv_raw_i(conv_raw), .rtc_alarm_i(rtc_alarm_i),
    .log_full_i(log_full_i), .conv_req_o(conv_req_o), .log_store_o(log_store_o),
    .hist_update_o(hist_update_o), .conv_code_o(conv_code_o),
    .mission_active_o(mission_active_o), .low_power_o(low_power_o),
    .search_match_o(search_match_o), .clear_mem_o(clear_mem_o));

  lmc_conv_model #(.LAT(LAT)) i_lmc_conv_model (
    .clk_i(clk_i), .nrst_i(nrst_i), .conv_req_i(conv_req_o), .force_i(force_q),
    .raw_i(raw_q), .conv_valid_o(conv_valid), .conv_raw_o(conv_raw));

  // ==========================================================
  // clock and pulse monitor
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (conv_req_o === 1'b1) begin
      n_req++;
      t_req = cyc;
    end
    if (log_store_o === 1'b1) n_store++;
    if (hist_update_o === 1'b1) n_hist++;
    if (clear_mem_o === 1'b1) n_clr++;
  end

  // ==========================================================
  // access and compare tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    wr_addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [9:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_addr_i <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(nm, e, rd_data_o);
  endtask
  task automatic mem(input logic c);
    @(posedge clk_i);
    mem_cmd_i <= 1'b1;
    mem_cmd_clear_i <= c;
    @(posedge clk_i);
    mem_cmd_i <= 1'b0;
    mem_cmd_clear_i <= 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic mchk(input logic e);
    repeat (2) @(negedge clk_i);
    chkb("mission_active", e, mission_active_o);
  endtask
  task automatic conv(input int r);
    @(posedge clk_i);
    raw_q <= 12'(r);
    force_q <= 1'b1;
    @(posedge clk_i);
    force_q <= 1'b0;
    repeat (LAT + 1) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic start(input logic [7:0] ctl, input logic [7:0] dly, input logic [7:0] ivl);
    wr(LMC_ADDR_CONTROL, 8'h40);
    mem(1'b1);
    wr(LMC_ADDR_CONTROL, ctl);
    wr(LMC_ADDR_DELAY_LO, dly);
    wr(LMC_ADDR_DELAY_HI, 8'h00);
    wr(LMC_ADDR_INTERVAL, ivl);
    mchk(1'b1);
    // settled here: the start edge is one before the last counted edge
    t0 = cyc - 1;
  endtask
  // bounded wait for the next conversion request
  task automatic wait_req();
    int n;
    int i;
    n = n_req;
    i = 0;
    while (n_req == n && i < 500) begin
      @(negedge clk_i);
      i++;
    end
    if (n_req == n) begin
      n_mismatch++;
      $display("[FAIL] conv_req expected pulse seen none");
      finish_test();
    end
  endtask
  function automatic logic [7:0] exp_code(input int r);
    int c;
    c = r + LMC_CODE_OFFSET_H;
    if (c < 0) return 8'h00;
    if (c > 255) return 8'hff;
    return c[7:0];
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    rchk("ctl_reset", LMC_ADDR_CONTROL, 8'h00);
    rchk("status_reset", LMC_ADDR_STATUS, 8'h80);
    rchk("unmapped", 10'h20f, 8'h00);
    chkb("low_power", 1'b0, low_power_o);
    $display("test reset done");
    wr(LMC_ADDR_LOW_TH, 8'h20);
    wr(LMC_ADDR_HIGH_TH, 8'he0);
    rchk("low_th", LMC_ADDR_LOW_TH, 8'h20);
    rchk("high_th", LMC_ADDR_HIGH_TH, 8'he0);
    wr(LMC_ADDR_DELAY_LO, 8'h34);
    wr(LMC_ADDR_DELAY_HI, 8'h12);
    rchk("delay_lo", LMC_ADDR_DELAY_LO, 8'h34);
    rchk("delay_hi", LMC_ADDR_DELAY_HI, 8'h12);
    wr(LMC_ADDR_CONTROL, 8'hff);
    rchk("ctl_all", LMC_ADDR_CONTROL, 8'hdf);
    chkb("low_power", 1'b1, low_power_o);
    mem(1'b0);
    rchk("ctl_arm_drop", LMC_ADDR_CONTROL, 8'h9f);
    chkb("no_clear", 1'b1, n_clr == 0);
    wr(LMC_ADDR_CONTROL, 8'h00);
    wr(LMC_ADDR_INTERVAL, 8'h05);
    mchk(1'b0);
    rchk("interval", LMC_ADDR_INTERVAL, 8'h05);
    wr(LMC_ADDR_CONTROL, 8'h40);
    mem(1'b1);
    chkb("clear_pulse", 1'b1, n_clr == 1);
    rchk("ctl_after_clear", LMC_ADDR_CONTROL, 8'h00);
    rchk("interval_cleared", LMC_ADDR_INTERVAL, 8'h00);
    rchk("delay_cleared", LMC_ADDR_DELAY_HI, 8'h00);
    rchk("status_cleared", LMC_ADDR_STATUS, 8'hc0);
    wr(LMC_ADDR_CONTROL, 8'h10);
    wr(LMC_ADDR_INTERVAL, 8'h03);
    mchk(1'b0);
    $display("test registers done");
    for (int k = 0; k < 7; k++) begin
      conv(RAWS[k]);
      chk("conv_code", exp_code(RAWS[k]), conv_code_o);
      rchk("forced", LMC_ADDR_FORCED, exp_code(RAWS[k]));
    end
    $display("test codes done");
    wr(LMC_ADDR_STATUS, 8'h00);
    @(posedge clk_i);
    log_full_i <= 1'b1;
    raw_q <= 12'sd132;
    start(8'h06, 8'h02, 8'h03);
    rchk("status_start", LMC_ADDR_STATUS, 8'ha0);
    chkb("search_idle", 1'b0, search_match_o);
    wait_req();
    t1 = t_req;
    chkb("first_conv", 1'b1, t1 - t0 >= 4 * TICK_N + 2 && t1 - t0 <= 5 * TICK_N + 1);
    repeat (8) @(negedge clk_i);
    chk("mission_code", 8'h10, conv_code_o);
    chkb("hist", 1'b1, n_hist == 1);
    chkb("store_full", 1'b1, n_store == 0);
    chkb("search_low", 1'b1, search_match_o);
    rchk("status_low", LMC_ADDR_STATUS, 8'ha4);
    @(posedge clk_i);
    raw_q <= 12'sd356;
    rtc_alarm_i <= 1'b1;
    @(posedge clk_i);
    rtc_alarm_i <= 1'b0;
    wait_req();
    chkb("interval_gap", 1'b1, t_req - t1 == 3 * TICK_N);
    repeat (8) @(negedge clk_i);
    rchk("status_high", LMC_ADDR_STATUS, 8'ha7);
    wr(LMC_ADDR_CONTROL, 8'h00);
    mchk(1'b0);
    rchk("ctl_kept", LMC_ADDR_CONTROL, 8'h06);
    wr(LMC_ADDR_CONTROL, 8'h02);
    rchk("ctl_second", LMC_ADDR_CONTROL, 8'h02);
    chkb("search_high", 1'b1, search_match_o);
    wr(LMC_ADDR_CONTROL, 8'h01);
    rchk("ctl_timer", LMC_ADDR_CONTROL, 8'h01);
    chkb("search_timer", 1'b1, search_match_o);
    $display("test mission done");
    start(8'h08, 8'h00, 8'h01);
    wait_req();
    repeat (7) @(negedge clk_i);
    chkb("store_wrap", 1'b1, n_store >= 1);
    wr(LMC_ADDR_LOW_TH, 8'h30);
    mchk(1'b0);
    rchk("low_kept", LMC_ADDR_LOW_TH, 8'h20);
    $display("test wrap done");
    start(8'h80, 8'h00, 8'h01);
    chkb("low_power_mission", 1'b1, low_power_o);
    n0 = n_req;
    repeat (100) @(negedge clk_i);
    chkb("no_ticks", 1'b1, n_req == n0);
    wr(LMC_ADDR_STATUS, 8'h00);
    mchk(1'b0);
    $display("test oscillator done");
    finish_test();
  end
endmodule
